// file: pkg/lvds_rx_defs.svh
// Register map, field positions, reset values and counts of the receive channel.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef LVDS_RX_DEFS_SVH
`define LVDS_RX_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONFIG 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_DATA 8'h0c

// ----------------------------------------
// Config fields
// ----------------------------------------
`define CFG_MODE_LSB 0
`define CFG_FACTOR_LSB 4
`define CFG_ROLL_LSB 8
`define CFG_EDGE_BIT 12
`define CFG_HOLD_BIT 13
`define CFG_RESET 32'h0000_0881
`define CFG_WMASK 32'h0000_3fff

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define CTL_SLIP_BIT 0
`define CTL_CHRST_BIT 1
`define CTL_FIFORST_BIT 2
`define STS_LOCK_BIT 0
`define STS_ROLL_BIT 1
`define STS_PHASE_LSB 4
`define STS_SLIP_LSB 8

// ----------------------------------------
// Sizes and counts
// ----------------------------------------
`define PHASE_COUNT 8
`define PHASE_HALF 3'h4
`define TRAIN_REPEATS 9'd256
`define FIFO_DEPTH 3'd6
`define FIFO_FILL 3'd3
`define WORD_MAX 10
`define DELAY_MAX 11

`endif

// file: pkg/lvds_rx_pkg.sv
// Types shared by the receive channel and its synchroniser.
// Assumes lvds_rx_defs.svh for the numeric constants.
package lvds_rx_pkg;

  typedef enum logic [2:0] {
    MODE_NO_ALIGN = 3'b000,
    MODE_ALIGN = 3'b001,
    MODE_SOFT_RECOVERY = 3'b010,
    MODE_BYPASS_DDR = 3'b011,
    MODE_BYPASS_SDR = 3'b100
  } rx_mode_type;

  typedef logic [2:0] phase_type;
  typedef logic [9:0] word_type;

endpackage

// file: hw/rx_sync_fifo.sv
// One bit wide, six deep synchroniser between chosen phase and serial clock.
// Assumes one write and, once primed, one read per sys_clk edge.
`timescale 1ns/1ps
`include "lvds_rx_defs.svh"

module rx_sync_fifo
(
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic rd_bit,
  output logic rd_valid
);
  import lvds_rx_pkg::*;

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  logic [5:0] mem_q;
  logic [2:0] wr_ptr_q;
  logic [2:0] rd_ptr_q;
  logic primed_q;
  wire [2:0] wr_ptr_nxt = (wr_ptr_q == `FIFO_DEPTH - 3'd1) ? 3'd0 : wr_ptr_q + 3'd1;
  wire [2:0] rd_ptr_nxt = (rd_ptr_q == `FIFO_DEPTH - 3'd1) ? 3'd0 : rd_ptr_q + 3'd1;
  // Reads trail writes by half the depth: only phase, never rate, is absorbed
  wire rd_en = primed_q & wr_en;

  always_ff @(posedge sys_clk)
  begin
    if (clear)
    begin
      mem_q <= 6'h00;
      wr_ptr_q <= 3'd0;
      rd_ptr_q <= 3'd0;
      primed_q <= 1'b0;
      rd_bit <= 1'b0;
      rd_valid <= 1'b0;
    end
    else
    begin
      if (wr_en)
      begin
        mem_q[wr_ptr_q] <= wr_bit;
        wr_ptr_q <= wr_ptr_nxt;
      end
      if (wr_en && wr_ptr_q == `FIFO_FILL - 3'd1)
        primed_q <= 1'b1;
      if (rd_en)
        rd_ptr_q <= rd_ptr_nxt;
      rd_bit <= mem_q[rd_ptr_q];
      rd_valid <= rd_en;
    end
  end

endmodule

// file: hw/lvds_rx_phase_align_deser.sv
// Receive channel: phase aligner, synchroniser, bit-slip realigner, deserialiser.
// Assumes eight oversampled phases of each serial bit arrive per sys_clk edge,
// and a classic Wishbone master on the same clock.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "lvds_rx_defs.svh"

module lvds_rx_phase_align_deser
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] rx_samples,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output lvds_rx_pkg::word_type rx_word,
  output logic rx_word_valid,
  output logic rx_par_clk,
  output logic rx_lock,
  output lvds_rx_pkg::phase_type rx_phase,
  output logic rx_rollover
);
  import lvds_rx_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [3:0] first_edge(input logic [7:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `PHASE_COUNT; i++)
    begin
      if (!r[3] && (s[i] != s[(i + 1) % `PHASE_COUNT]))
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  function automatic logic [9:0] word_mask(input logic [3:0] factor);
    logic [9:0] m;
    m = 10'h000;
    for (int i = 0; i < `WORD_MAX; i++)
    begin
      if (4'(i) < factor)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic [7:0] samp_meta_q;
  logic [7:0] samp_q;

  always_ff @(posedge sys_clk)
  begin
    samp_meta_q <= rx_samples;
    samp_q <= samp_meta_q;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] cfg_q;
  logic slip_req_q;
  logic chrst_q;
  logic fiforst_q;
  logic [9:0] word_q;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire hit_cfg = (wb_adr_i == `ADDR_CONFIG);
  wire hit_ctl = (wb_adr_i == `ADDR_CONTROL);
  wire hit_sts = (wb_adr_i == `ADDR_STATUS);
  wire hit_dat = (wb_adr_i == `ADDR_DATA);
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] cfg_d = ((cfg_q & ~lane_mask) | (wb_dat_i & lane_mask)) & `CFG_WMASK;
  wire ctl_wr = bus_wr & hit_ctl & wb_sel_i[0];

  rx_mode_type mode;
  assign mode = rx_mode_type'(cfg_q[`CFG_MODE_LSB +: 3]);
  wire [3:0] factor = cfg_q[`CFG_FACTOR_LSB +: 4];
  wire [3:0] roll_point = cfg_q[`CFG_ROLL_LSB +: 4];
  wire edge_sel = cfg_q[`CFG_EDGE_BIT];
  wire hold = cfg_q[`CFG_HOLD_BIT];
  wire aligning = (mode == MODE_ALIGN) | (mode == MODE_SOFT_RECOVERY);
  wire bypass = (mode == MODE_BYPASS_DDR) | (mode == MODE_BYPASS_SDR);

  // ----------------------------------------
  // Phase aligner
  // ----------------------------------------
  phase_type phase_q;
  logic [8:0] stable_cnt_q;
  logic locked_once_q;
  logic first_lock_q;

  wire [3:0] edge_info = first_edge(samp_q);
  wire edge_found = edge_info[3];
  // Sample opposite the edge: worst offset is one phase step
  wire [2:0] target = edge_info[2:0] + `PHASE_HALF;
  wire [2:0] phase_diff = target - phase_q;
  wire step_up = (phase_diff < `PHASE_HALF);
  wire move = aligning & edge_found & ~hold & (target != phase_q);
  wire chan_clear = ~rst_n | chrst_q;
  wire lock_now = aligning & edge_found & ~rx_lock & (stable_cnt_q == `TRAIN_REPEATS - 9'd1);

  always_ff @(posedge sys_clk)
  begin
    if (chan_clear)
    begin
      phase_q <= 3'd0;
      stable_cnt_q <= 9'd0;
      rx_lock <= 1'b0;
      locked_once_q <= 1'b0;
    end
    else if (move)
    begin
      // One adjacent step at a time, so any step ends lock
      phase_q <= step_up ? phase_q + 3'd1 : phase_q - 3'd1;
      stable_cnt_q <= 9'd0;
      rx_lock <= 1'b0;
    end
    else if (aligning & edge_found & ~rx_lock)
    begin
      stable_cnt_q <= stable_cnt_q + 9'd1;
      if (lock_now)
      begin
        rx_lock <= 1'b1;
        locked_once_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (chan_clear)
      first_lock_q <= 1'b0;
    else
      first_lock_q <= lock_now & ~locked_once_q;
  end

  // ----------------------------------------
  // Sampling and synchroniser
  // ----------------------------------------
  wire fixed_bit = edge_sel ? samp_q[4] : samp_q[0];
  wire chosen_bit = aligning ? samp_q[phase_q] : fixed_bit;
  wire fifo_bit;
  wire fifo_valid;
  wire fifo_clear = ~rst_n | first_lock_q | fiforst_q;

  rx_sync_fifo rx_sync_fifo_inst
  (
    .sys_clk(sys_clk),
    .clear(fifo_clear),
    .wr_en(mode == MODE_ALIGN),
    .wr_bit(chosen_bit),
    .rd_bit(fifo_bit),
    .rd_valid(fifo_valid)
  );

  // Soft recovery shifts straight from the chosen phase
  wire stream_bit = (mode == MODE_ALIGN) ? fifo_bit : chosen_bit;
  wire stream_valid = (mode == MODE_ALIGN) ? fifo_valid : ~bypass;

  // ----------------------------------------
  // Realigner
  // ----------------------------------------
  logic [10:0] dly_q;
  logic [3:0] slip_cnt_q;
  logic slip_seen_q;

  wire [3:0] tap = slip_cnt_q - 4'd1;
  wire aligned_bit = (slip_cnt_q == 4'd0) ? stream_bit : dly_q[tap];
  logic [3:0] bit_cnt_q;
  wire word_end = (bit_cnt_q == factor - 4'd1) | (bit_cnt_q >= 4'(`WORD_MAX - 1));
  wire tick = bypass | (stream_valid & word_end);
  // Sampled once per parallel period; a long high level is one edge
  wire slip_rise = tick & ~bypass & slip_req_q & ~slip_seen_q;
  wire [3:0] slip_next = slip_cnt_q + 4'd1;
  // Rollover point below the factor cannot slip through a word
  wire roll_event = slip_rise & (slip_next >= roll_point);

  always_ff @(posedge sys_clk)
  begin
    if (~rst_n)
    begin
      dly_q <= 11'h000;
      slip_cnt_q <= 4'd0;
      slip_seen_q <= 1'b0;
      rx_rollover <= 1'b0;
    end
    else
    begin
      if (stream_valid)
        dly_q <= {dly_q[9:0], stream_bit};
      if (tick)
      begin
        slip_seen_q <= slip_req_q;
        rx_rollover <= roll_event;
      end
      if (roll_event)
        slip_cnt_q <= 4'd0;
      else if (slip_rise && slip_next <= 4'(`DELAY_MAX))
        slip_cnt_q <= slip_next;
    end
  end

  // ----------------------------------------
  // Deserialiser and bypass capture
  // ----------------------------------------
  logic [9:0] sreg_q;
  wire [9:0] shifted = {sreg_q[8:0], aligned_bit};
  wire [9:0] ddr_word = {8'h00, samp_q[0], samp_q[4]};
  // Single rate has no capture register; the output flop follows the two pin synchroniser stages
  wire [9:0] sdr_word = {9'h000, samp_q[0]};
  wire [9:0] par_word = (mode == MODE_BYPASS_DDR) ? ddr_word : (mode == MODE_BYPASS_SDR) ? sdr_word :
    (shifted & word_mask(factor));
  wire [3:0] half_factor = {1'b0, factor[3:1]};

  always_ff @(posedge sys_clk)
  begin
    if (~rst_n)
    begin
      sreg_q <= 10'h000;
      bit_cnt_q <= 4'd0;
      word_q <= 10'h000;
      rx_word_valid <= 1'b0;
      rx_par_clk <= 1'b0;
    end
    else
    begin
      if (stream_valid)
      begin
        sreg_q <= shifted;
        bit_cnt_q <= word_end ? 4'd0 : bit_cnt_q + 4'd1;
      end
      if (tick)
        word_q <= par_word;
      rx_word_valid <= tick;
      rx_par_clk <= ~bypass & (bit_cnt_q < half_factor);
    end
  end

  assign rx_word = word_q;
  assign rx_phase = phase_q;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  wire [31:0] status_word = {20'h00000, slip_cnt_q, 1'b0, phase_q, 2'b00, rx_rollover, rx_lock};
  wire [31:0] read_word = hit_cfg ? cfg_q : hit_sts ? status_word : hit_dat ? {22'h000000, word_q} :
    32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (~rst_n)
    begin
      cfg_q <= `CFG_RESET;
      slip_req_q <= 1'b0;
      chrst_q <= 1'b0;
      fiforst_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? read_word : 32'h0000_0000;
      if (bus_wr && hit_cfg)
        cfg_q <= cfg_d;
      if (ctl_wr)
        slip_req_q <= wb_dat_i[`CTL_SLIP_BIT];
      chrst_q <= ctl_wr & wb_dat_i[`CTL_CHRST_BIT];
      fiforst_q <= ctl_wr & wb_dat_i[`CTL_FIFORST_BIT];
    end
  end

endmodule

// file: tb/lvds_rx_phase_align_deser_monitor.sv
// Port checker for the receive channel.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lvds_rx_monitor
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire lvds_rx_pkg::word_type rx_word,
  input wire logic rx_word_valid,
  input wire logic rx_lock,
  input wire lvds_rx_pkg::phase_type rx_phase,
  input wire logic rx_rollover
);
  import lvds_rx_pkg::*;
  logic [9:0] quiet_q;
  logic [3:0] roll_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Helper counts
  // ----------------------------------------
  // Saturating, so a long steady lock never wraps
  always_ff @(posedge sys_clk)
  begin
    quiet_q <= (!rst_n || $changed(rx_phase)) ? 10'h000 : quiet_q + {9'h000, quiet_q != 10'h3ff};
    roll_q <= (rst_n && rx_rollover) ? roll_q + 4'h1 : 4'h0;
  end
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0f |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  lock_drop_a: assert property ($changed(rx_phase) |-> ##[0:1] !rx_lock)
    else $error("lock kept over phase step");
  lock_train_a: assert property ($rose(rx_lock) |-> quiet_q >= 10'd255)
    else $error("lock before training run");
  word_hold_a: assert property ($changed(rx_word) |-> rx_word_valid)
    else $error("word changed without valid");
  roll_width_a: assert property (roll_q <= 4'ha)
    else $error("rollover too long");
  cover property ($rose(rx_lock));
  cover property ($rose(rx_rollover));
  cover property (wb_ack_o && wb_we_i);
endmodule
bind lvds_rx_phase_align_deser lvds_rx_monitor lvds_rx_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_lock(rx_lock),
  .rx_phase(rx_phase), .rx_rollover(rx_rollover));

// file: tb/serial_source_model.sv
// Upstream sender: repeats one word MSB first, eight phase samples per bit.
// Assumes the bench changes word, width and skew right after an edge.
`timescale 1ns/1ps
module serial_source_model
(
  input wire logic sys_clk,
  input wire logic [9:0] pattern,
  input wire logic [3:0] width,
  input wire logic [2:0] skew,
  output logic [7:0] samples
);
  logic [3:0] idx_q = 4'h0;
  logic last_q = 1'b0;
  initial samples = 8'h00;
  // Phases before the skew point still see the previous bit
  always @(posedge sys_clk)
  begin
    idx_q <= (idx_q == 4'h0) ? width - 4'h1 : idx_q - 4'h1;
    last_q <= pattern[idx_q];
    for (int i = 0; i < 8; i++)
      samples[i] <= (i < skew) ? last_q : pattern[idx_q];
  end
endmodule

// file: tb/test_lvds_rx_phase_align_deser.sv
// Self-checking bench for the receive channel through its register bus.
// Assumes the sender model and the checker are compiled before it.
`timescale 1ns/1ps
`include "lvds_rx_defs.svh"
module test_lvds_rx_phase_align_deser;
  import lvds_rx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [9:0] pat = 10'h2b4;
  logic [3:0] nb = 4'h8;
  logic [2:0] skew = 3'h4;
  logic [7:0] smp;
  logic [3:0] fac [5] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'ha};
  logic ack, valid, pclk, lock, roll;
  word_type word, w;
  phase_type ph, p0;
  int num_errors = 0;
  int num_checks = 0;
  int rolls = 0;
  int hi = 0;
  logic [3:0] sel = 4'h0;
  logic [3:0] bsel = 4'hf;
  serial_source_model serial_source_model_inst (.sys_clk(sys_clk), .pattern(pat), .width(nb), .skew(skew),
    .samples(smp));
  lvds_rx_phase_align_deser lvds_rx_phase_align_deser_inst (.sys_clk(sys_clk), .rst_n(rst_n), .rx_samples(smp),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_word(word), .rx_word_valid(valid), .rx_par_clk(pclk),
    .rx_lock(lock), .rx_phase(ph), .rx_rollover(roll));
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (roll === 1'b1) rolls++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle, held until ack is seen at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    sel <= bsel;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk(n, 0);
  endtask
  task automatic words(input int k);
    int n;
    n = 0;
    repeat (k)
    begin
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (valid !== 1'b1 && n < 300);
    end
    if (n >= 300) chk(n, 0);
  endtask
  task automatic until_lock(input logic l);
    int n;
    n = 0;
    while (lock !== l && n < 1500)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(lock, l);
  endtask
  function automatic word_type ror(input word_type v);
    return {2'b00, v[0], v[7:1]};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, `ADDR_CONFIG, 0);
    chk(rdat, `CFG_RESET);
    bus(0, `ADDR_CONTROL, 0);
    chk(rdat, 0);
    bus(1, 8'h10, 32'hffff_ffff);
    bus(0, 8'h10, 0);
    chk(rdat, 0);
    bsel = 4'h2;
    bus(1, `ADDR_CONFIG, 32'hffff_ffff);
    bsel = 4'hf;
    bus(0, `ADDR_CONFIG, 0);
    chk(rdat, 32'h0000_3f81);
    foreach (fac[i])
    begin
      bus(1, `ADDR_CONFIG, {20'h0, 4'hb, fac[i], 4'h0});
      nb <= fac[i];
      words(4);
      w = word;
      words(1);
      chk(word, w);
      chk(word >> fac[i], 0);
      bus(0, `ADDR_DATA, 0);
      chk(rdat, {22'h0, w});
    end
    nb <= 4'h8;
    bus(1, `ADDR_CONFIG, 32'h1880);
    words(4);
    w = word;
    bus(1, `ADDR_CONFIG, 32'h0880);
    words(4);
    chk(word, ror(w));
    for (int k = 1; k <= 8; k++)
    begin
      w = word;
      bus(1, `ADDR_CONTROL, 1);
      words(2);
      chk(word, ror(w));
      words(3);
      chk(word, ror(w));
      bus(0, `ADDR_STATUS, 0);
      chk(rdat[11:8], k % 8);
      chk(rolls != 0, k == 8);
      bus(1, `ADDR_CONTROL, 0);
      words(2);
    end
    skew <= 3'h3;
    bus(1, `ADDR_CONFIG, 32'h0881);
    bus(1, `ADDR_CONTROL, 2);
    until_lock(1);
    p0 = ph;
    chk(3'(ph + 3'h2) <= 3'h2, 1);
    words(3);
    w = word;
    words(1);
    chk(word, w);
    bus(1, `ADDR_CONFIG, 32'h2881);
    skew <= 3'h6;
    repeat (300) @(posedge sys_clk);
    chk(ph, p0);
    chk(lock, 1);
    bus(1, `ADDR_CONFIG, 32'h0881);
    until_lock(0);
    until_lock(1);
    bus(1, `ADDR_CONTROL, 4);
    words(4);
    w = word;
    words(1);
    chk(word, w);
    bus(1, `ADDR_CONTROL, 2);
    repeat (2) @(posedge sys_clk);
    chk(lock, 0);
    until_lock(1);
    bus(1, `ADDR_CONFIG, 32'h0882);
    words(3);
    w = word;
    words(1);
    chk(word, w);
    hi = 0;
    repeat (8)
    begin
      @(posedge sys_clk);
      hi += pclk;
    end
    chk(hi, 4);
    skew <= 3'h4;
    bus(1, `ADDR_CONFIG, 32'h0883);
    repeat (4) @(posedge sys_clk);
    chk({pclk, valid, word[9:2]}, 10'h100);
    w = word;
    @(posedge sys_clk);
    chk(word[1], w[0]);
    bus(1, `ADDR_CONFIG, 32'h0884);
    repeat (4) @(posedge sys_clk);
    chk({pclk, valid, word[9:1]}, 11'h200);
    end_sim();
  end
endmodule
